// ---- ppu_pkg.sv ----
/*
 * constants, field layouts and carrier structs for the port p upper pin block.
 * assumes a single 10 mhz system clock and an 8-bit register port.
 */
// Overview of operation
// [RULE1] data register readable and writable any time
// [RULE2] read gives register if output, else pin
// [RULE3] plain output drives stored data bit
// [RULE4] ext irq enable forces bit 5 input
// [RULE5] ext irq beats pulse-width and plain io
// [RULE6] enabled pulse-width channel owns its pin
// [RULE7] driver routing blocks pulse-width on pin
// [RULE8] alternate-port routing blocks pulse-width on pin
// [RULE9] pin interrupts in input or output mode
// [RULE10] bits 5,4 feed trigger, io unchanged
// [RULE11] bit 2 plain io or switched supply
// [RULE12] bit 2 over-current interrupt when enabled
// [RULE13] direction bit selects io; irq leaves it
// [RULE14] pin inputs pass two-flop synchroniser
`default_nettype none
package ppu_pkg;
    localparam int NPIN = 4;          // pins 5..2
    localparam int PIN_LO = 2;        // lowest pin covered
    localparam int IRQ_IDX = 3;       // pin 5 within the group
    localparam int SUPPLY_IDX = 0;    // pin 2 within the group
    localparam int TRIG_LO = 2;       // pins 4,5 within the group
    // register addresses (indices)
    localparam logic [3:0] A_DATA = 4'h0;
    localparam logic [3:0] A_DIR = 4'h1;
    localparam logic [3:0] A_IRQCTL = 4'h2;
    localparam logic [3:0] A_PIE = 4'h3;
    localparam logic [3:0] A_ST = 4'h4;
    localparam logic [3:0] A_CLR = 4'h5;
    localparam logic [3:0] A_EN = 4'h6;
    localparam logic [3:0] A_MODE = 4'h7;
    // field positions
    localparam int F_IRQ_PIN_EN = 6;  // ext_irq_pin_enable in ext_irq_control
    localparam int F_OCIE = 0;        // over-current enable in mode register
    localparam int F_SUPPLY = 1;      // bit 2 as supply in mode register
    localparam int ST_OC = 4;         // status bit of over-current event
    localparam logic [7:0] RST_Z = 8'h00;
    typedef enum logic [2:0] {
        PPU_IO = 3'h1,
        PPU_PWM = 3'h2,
        PPU_IRQ = 3'h4
    } ppu_own_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ppu_bus_t;
    typedef struct packed {
        logic [NPIN-1:0] pwm_en;
        logic [NPIN-1:0] pwm_out;
        logic [NPIN-1:0] drv_routed;
        logic [NPIN-1:0] alt_routed;
    } ppu_pwm_t;
endpackage
`default_nettype wire

// ---- ppu_sync.sv ----
/*
 * two-flop synchroniser for a vector of pin levels.
 * assumes asynchronous pin inputs and an active-low async reset.
 */
`default_nettype none
module ppu_sync #(
    parameter int W = 4
) (
    input wire logic clk_sys_i,      // system clock
    input wire logic nrst_i,         // async reset, low
    input wire logic [W-1:0] d_i,    // raw levels
    output logic [W-1:0] q_o         // synchronised levels
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    // an empty vector would leave nothing to synchronise
    if (W < 1) begin : g_bad_width
        $error("ppu_sync: width must be positive");
    end
    // first flop feeds only the second, avoiding metastable fan-out
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= d_i;                 // [RULE14]
            s2_q <= s1_q;
        end
    end
    assign q_o = s2_q;
endmodule
`default_nettype wire

// ---- ppu_pinmux.sv ----
/*
 * per-pin ownership and drive selection for pins 5..2.
 * assumes data, direction and irq enable come from flip-flops in the top module; pulse-width controls come from top ports.
 */
`default_nettype none
module ppu_pinmux #(
    parameter int N = 4
) (
    input wire logic [N-1:0] data_i,    // stored data bits
    input wire logic [N-1:0] dir_i,     // direction, 1 = out
    input wire logic irq_en_i,          // ext irq pin enable
    input wire ppu_pkg::ppu_pwm_t pwm_i,// pulse-width controls
    output logic [N-1:0] out_o,         // pin drive value
    output logic [N-1:0] oe_n_o         // low while driven
);
    // pulse-width struct width is fixed by the package, so N must follow it
    if (N != ppu_pkg::NPIN || N <= ppu_pkg::IRQ_IDX) begin : g_bad_n
        $error("ppu_pinmux: N must match the package pin count");
    end
    // ownership: irq first, then pulse-width, then plain io
    always_comb begin
        for (int i = 0; i < N; i++) begin
            out_o[i] = data_i[i];                       // [RULE3] [RULE11]
            oe_n_o[i] = ~dir_i[i];                      // [RULE13]
            if (pwm_i.pwm_en[i] && !pwm_i.drv_routed[i] // [RULE7]
                && !pwm_i.alt_routed[i]) begin          // [RULE8]
                out_o[i] = pwm_i.pwm_out[i];            // [RULE6]
                oe_n_o[i] = 1'b0;
            end
            if (i == ppu_pkg::IRQ_IDX && irq_en_i) begin
                out_o[i] = 1'b0;
                oe_n_o[i] = 1'b1;                       // [RULE4] [RULE5]
            end
        end
    end
endmodule
`default_nettype wire

// ---- ppu_top.sv ----
/*
 * register file, read mux, pin and over-current interrupts for port p pins 5..2.
 * assumes a synchronous register port with one-cycle read latency and
 * that pulse-width and routing controls come from their own blocks.
 */
`default_nettype none
module ppu_top (
    input wire logic clk_sys_i,               // 10 mhz system clock
    input wire logic nrst_i,                  // async reset, low
    input wire logic [3:0] addr_i,            // register index
    input wire logic [7:0] wdata_i,           // write data
    input wire logic wr_i,                    // write strobe
    input wire logic rd_i,                    // read strobe
    output logic [7:0] rdata_o,               // read data, cycle after rd
    input wire logic [3:0] pin_i,             // pin levels 5..2
    output logic [3:0] pin_o,                 // pin drive 5..2
    output logic [3:0] pin_oe_n_o,            // low while driven
    input wire ppu_pkg::ppu_pwm_t pwm_i,      // pulse-width controls
    input wire logic overcurrent_i,           // supply over-current level
    output logic ext_irq_o,                   // synchronised irq level, pin 5
    output logic [1:0] conversion_trigger_o,  // pins 5,4 trigger levels
    output logic supply_on_o,                 // bit 2 acts as supply
    output logic irq_o                        // combined interrupt level
);
    localparam int N = ppu_pkg::NPIN;
    ppu_pkg::ppu_bus_t bus;
    logic [N-1:0] port_p_data_q;
    logic [N-1:0] port_p_direction_q;
    logic [7:0] ext_irq_control_q;
    logic [N-1:0] pie_q;
    logic [7:0] st_q;
    logic [7:0] st_set;
    logic [7:0] clr;
    logic [7:0] en_q;
    logic [1:0] mode_q;
    logic [N-1:0] pin_s;
    logic [N-1:0] pin_prev_q;
    logic oc_s;
    logic oc_prev_q;
    logic [N-1:0] ownr_oe_n;
    logic [7:0] rd_d;
    logic [7:0] rdata_q;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // register write hit test, shared by every register
    function automatic logic hit(input ppu_pkg::ppu_bus_t b, input logic [3:0] a);
        hit = b.wr && (b.addr == a);
    endfunction

    ppu_sync #(.W(N + 1)) u_sync (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .d_i({overcurrent_i, pin_i}),
        .q_o({oc_s, pin_s})
    );

    ppu_pinmux #(.N(N)) u_mux (
        .data_i(port_p_data_q),
        .dir_i(port_p_direction_q),
        .irq_en_i(ext_irq_control_q[ppu_pkg::F_IRQ_PIN_EN]),
        .pwm_i(pwm_i),
        .out_o(pin_o),
        .oe_n_o(ownr_oe_n)
    );
    assign pin_oe_n_o = ownr_oe_n;

    // data register, writable any time
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_p_data_q <= ppu_pkg::RST_Z[N-1:0];
        end else if (hit(bus, ppu_pkg::A_DATA)) begin
            port_p_data_q <= bus.wdata[ppu_pkg::PIN_LO +: N];  // [RULE1]
        end
    end

    // direction stays as written even while irq forces input
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_p_direction_q <= ppu_pkg::RST_Z[N-1:0];
        end else if (hit(bus, ppu_pkg::A_DIR)) begin
            port_p_direction_q <= bus.wdata[ppu_pkg::PIN_LO +: N];  // [RULE13]
        end
    end

    // control registers
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext_irq_control_q <= ppu_pkg::RST_Z;
            pie_q <= ppu_pkg::RST_Z[N-1:0];
            en_q <= ppu_pkg::RST_Z;
            mode_q <= ppu_pkg::RST_Z[1:0];
        end else begin
            if (hit(bus, ppu_pkg::A_IRQCTL)) begin
                ext_irq_control_q <= bus.wdata;       // [RULE4]
            end
            if (hit(bus, ppu_pkg::A_PIE)) begin
                pie_q <= bus.wdata[ppu_pkg::PIN_LO +: N];
            end
            if (hit(bus, ppu_pkg::A_EN)) begin
                en_q <= bus.wdata;
            end
            if (hit(bus, ppu_pkg::A_MODE)) begin
                mode_q <= bus.wdata[1:0];             // [RULE11]
            end
        end
    end

    assign supply_on_o = mode_q[ppu_pkg::F_SUPPLY];   // [RULE11]
    // triggers tap the synchronised level, never touching the drive
    assign conversion_trigger_o = pin_s[ppu_pkg::TRIG_LO +: 2];  // [RULE10]
    assign ext_irq_o = ext_irq_control_q[ppu_pkg::F_IRQ_PIN_EN] & pin_s[ppu_pkg::IRQ_IDX];

    // edge history, taken from the synchronised side only
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_prev_q <= ppu_pkg::RST_Z[N-1:0];
            oc_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_s;
            oc_prev_q <= oc_s;
        end
    end

    // any change counts, whatever the direction of the pin
    always_comb begin
        st_set = ppu_pkg::RST_Z;
        st_set[N-1:0] = pie_q & (pin_s ^ pin_prev_q);   // [RULE9]
        st_set[ppu_pkg::ST_OC] = mode_q[ppu_pkg::F_OCIE] & mode_q[ppu_pkg::F_SUPPLY]
                                 & oc_s & ~oc_prev_q;   // [RULE12]
        clr = hit(bus, ppu_pkg::A_CLR) ? bus.wdata : ppu_pkg::RST_Z;
    end

    // sticky status: a set in the clear cycle wins
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= ppu_pkg::RST_Z;
        end else begin
            st_q <= (st_q & ~clr) | st_set;
        end
    end

    assign irq_o = |(st_q & en_q);

    // read mux; data bits show register for outputs, pin for inputs
    always_comb begin
        rd_d = ppu_pkg::RST_Z;
        case (bus.addr)
            ppu_pkg::A_DATA: begin
                rd_d[ppu_pkg::PIN_LO +: N] = (port_p_direction_q & port_p_data_q)
                                           | (~port_p_direction_q & pin_s);  // [RULE2]
            end
            ppu_pkg::A_DIR: rd_d[ppu_pkg::PIN_LO +: N] = port_p_direction_q;
            ppu_pkg::A_IRQCTL: rd_d = ext_irq_control_q;
            ppu_pkg::A_PIE: rd_d[ppu_pkg::PIN_LO +: N] = pie_q;
            ppu_pkg::A_ST: rd_d = st_q;
            ppu_pkg::A_EN: rd_d = en_q;
            ppu_pkg::A_MODE: rd_d[1:0] = mode_q;
            default: rd_d = ppu_pkg::RST_Z;   // clear and unmapped read zero
        endcase
    end

    // read data valid only the cycle after the strobe
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= ppu_pkg::RST_Z;
        end else begin
            rdata_q <= bus.rd ? rd_d : ppu_pkg::RST_Z;  // [RULE1]
        end
    end
    assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// ---- ppu_checker.sv ----
/* assertions on the port p upper pin block, bound to ppu_top.
   assumes only the top ports are visible, so writes are shadowed here */
`default_nettype none
module ppu_checker (
    input wire logic clk_sys_i, // clock
    input wire logic nrst_i, // reset, low
    input wire logic [3:0] addr_i, // index
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    input wire logic [7:0] rdata_o, // read data
    input wire logic [3:0] pin_i, // pin levels
    input wire logic [3:0] pin_o, // pin drive
    input wire logic [3:0] pin_oe_n_o, // low = driven
    input wire ppu_pkg::ppu_pwm_t pwm_i, // pwm controls
    input wire logic overcurrent_i, // over-current
    input wire logic ext_irq_o, // ext irq level
    input wire logic [1:0] conversion_trigger_o, // trigger levels
    input wire logic supply_on_o, // supply mode
    input wire logic irq_o // interrupt
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    logic [3:0] dir_q, dat_q, pie_q, eff, io;
    logic [4:0] en_q;
    logic [1:0] mode_q, up_q;
    logic ie_q;
    // shadow of writable registers, needed because bodies are hidden
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {dir_q, dat_q, pie_q, en_q, mode_q, ie_q} <= '0;
        end else if (wr_i) begin
            case (addr_i)
                ppu_pkg::A_DATA: dat_q <= wdata_i[5:2];
                ppu_pkg::A_DIR: dir_q <= wdata_i[5:2];
                ppu_pkg::A_IRQCTL: ie_q <= wdata_i[ppu_pkg::F_IRQ_PIN_EN];
                ppu_pkg::A_PIE: pie_q <= wdata_i[5:2];
                ppu_pkg::A_EN: en_q <= wdata_i[4:0];
                ppu_pkg::A_MODE: mode_q <= wdata_i[1:0];
                default: ;
            endcase
        end
    end
    // warm-up count: synchroniser history is meaningless right after reset
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) up_q <= 2'h0;
        else up_q <= up_q + {1'b0, up_q != 2'h3};
    end
    // pins owned by pwm, and pins left to plain io
    assign eff = pwm_i.pwm_en & ~pwm_i.drv_routed & ~pwm_i.alt_routed & ~{ie_q, 3'h0};
    assign io = ~eff & ~{ie_q, 3'h0};
    sequence pin_evt;
        |((pin_i ^ $past(pin_i)) & pie_q & en_q[3:0]);
    endsequence
    sequence oc_evt;
        mode_q == 2'h3 && en_q[4] && $rose(overcurrent_i);
    endsequence
    chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    chk_read_dir: assert property (rd_i && addr_i == ppu_pkg::A_DIR |=>
        rdata_o == {2'h0, $past(dir_q), 2'h0}) else $error("direction readback wrong");
    chk_io_drive: assert property ((((pin_oe_n_o ^ ~dir_q) |
        ((pin_o ^ dat_q) & dir_q)) & io) == 4'h0) else $error("plain io drive wrong");
    chk_pwm_drive: assert property ((((pin_o ^ pwm_i.pwm_out) |
        pin_oe_n_o) & eff) == 4'h0) else $error("pwm drive wrong");
    chk_irq_input: assert property (ie_q |-> pin_oe_n_o[ppu_pkg::IRQ_IDX])
        else $error("irq pin not input");
    chk_trig_sync: assert property (up_q == 2'h3 |->
        conversion_trigger_o == $past(pin_i[3:2], 2)) else $error("trigger lag wrong");
    chk_supply_mode: assert property (supply_on_o == mode_q[ppu_pkg::F_SUPPLY])
        else $error("supply mode wrong");
    chk_oc_irq: assert property (oc_evt |-> ##[1:4] irq_o)
        else $error("over-current irq missing");
    chk_pin_irq: assert property (pin_evt |-> ##[1:4] irq_o)
        else $error("pin irq missing");
endmodule
bind ppu_top ppu_checker i_chk (.clk_sys_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .pin_i, .pin_o, .pin_oe_n_o, .pwm_i, .overcurrent_i, .ext_irq_o,
    .conversion_trigger_o, .supply_on_o, .irq_o);
`default_nettype wire

// ---- ppu_pins_model.sv ----
/* external side of port p pins 5..2: sensors and a supplied load.
   assumes pin_oe_n low while the block drives a pin */
`default_nettype none
module ppu_pins_model (
    input wire logic [3:0] pin_drv_i, // block drive
    input wire logic [3:0] pin_oe_n_i, // low = driven
    input wire logic supply_on_i, // pin 2 feeds load
    input wire logic [3:0] ext_i, // sensor levels
    input wire logic overload_i, // load too heavy
    output logic [3:0] pin_lvl_o, // resolved levels
    output logic overcurrent_o // over-current sense
);
    // sensors only win where the block lets go of the pin
    assign pin_lvl_o = (ext_i & pin_oe_n_i) | (pin_drv_i & ~pin_oe_n_i);
    // sense fires only while pin 2 really sources the load
    assign overcurrent_o = overload_i & supply_on_i & ~pin_oe_n_i[0] & pin_drv_i[0];
endmodule
`default_nettype wire

// ---- ppu_tb.sv ----
/* self-checking bench for ppu_top with a pins model at its far side.
   assumes the checker binds itself into ppu_top */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, ovl = 1'b0;
    logic [3:0] addr_i = 4'h0, ext = 4'h0, dir, dat, lv, pin_i, pin_o, pin_oe_n_o;
    logic [7:0] wdata_i = 8'h00, rdata_o, e;
    logic [31:0] r;
    logic [1:0] conversion_trigger_o;
    logic ext_irq_o, supply_on_o, irq_o, ocur;
    ppu_pkg::ppu_pwm_t pwm_i = '0;
    int seed = 32'h7E49, mismatches = 0, checks = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    ppu_top i_dut (.clk_sys_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_i,
        .pin_o, .pin_oe_n_o, .pwm_i, .overcurrent_i(ocur), .ext_irq_o,
        .conversion_trigger_o, .supply_on_o, .irq_o);
    ppu_pins_model i_pins (.pin_drv_i(pin_o), .pin_oe_n_i(pin_oe_n_o), .supply_on_i(supply_on_o),
        .ext_i(ext), .overload_i(ovl), .pin_lvl_o(pin_i), .overcurrent_o(ocur));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // idle cycle first, so back-to-back calls never touch a strobe twice
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] x);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(rdata_o, x);
    endtask
    task automatic nap(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    // expected {oe_n, drive}: irq beats pwm, pwm beats io
    function automatic logic [7:0] exp_pins(input logic [3:0] dr, input logic [3:0] dt,
        input logic ie, input ppu_pkg::ppu_pwm_t p);
        logic [3:0] ef, io;
        ef = p.pwm_en & ~p.drv_routed & ~p.alt_routed & ~{ie, 3'h0};
        io = ~ef & ~{ie, 3'h0};
        return {~((dr & io) | ef), (p.pwm_out & ef) | (dt & dr & io)};
    endfunction
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #500000;
        mismatches++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00);
        // random direction, data, irq enable, pins and pwm; two corners first
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            if (i < 2) r[31:8] = (i == 1) ? 24'hF5C300 : 24'hFA0001;
            {dir, dat} = r[7:0];
            wr(ppu_pkg::A_DIR, {2'h0, dir, 2'h0});
            wr(ppu_pkg::A_DATA, {2'h0, dat, 2'h0});
            wr(ppu_pkg::A_IRQCTL, {1'b0, r[8], 6'h00});
            @(posedge clk_sys_i);
            ext <= r[12:9];
            pwm_i <= r[31:16];
            nap(4);
            e = exp_pins(dir, dat, r[8], r[31:16]);
            lv = (ext & e[7:4]) | (e[3:0] & ~e[7:4]);
            chk({pin_oe_n_o, pin_o & ~pin_oe_n_o}, e);
            chk(conversion_trigger_o, lv[3:2]);
            chk(ext_irq_o, r[8] & lv[3]);
            rd(ppu_pkg::A_DATA, {2'h0, (dat & dir) | (lv & ~dir), 2'h0});
            rd(ppu_pkg::A_DIR, {2'h0, dir, 2'h0});
        end
        // pin interrupts: each input pin, then output mode, then masked
        @(posedge clk_sys_i);
        pwm_i <= '0;
        ext <= 4'h1;
        wr(ppu_pkg::A_IRQCTL, 8'h00);
        wr(ppu_pkg::A_DIR, 8'h00);
        wr(ppu_pkg::A_PIE, 8'h3F);
        wr(ppu_pkg::A_EN, 8'h1F);
        wr(ppu_pkg::A_CLR, 8'h1F);
        nap(1);
        chk(irq_o, 1'b0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys_i);
            ext <= ext ^ (4'h1 << i);
            nap(4);
            chk(irq_o, 1'b1);
            rd(ppu_pkg::A_ST, 8'h01 << i);
            wr(ppu_pkg::A_CLR, 8'h01 << i);
            nap(1);
            chk(irq_o, 1'b0);
        end
        wr(ppu_pkg::A_DATA, 8'h00);
        wr(ppu_pkg::A_DIR, 8'h3C);
        nap(4);
        chk(irq_o, 1'b1);
        rd(ppu_pkg::A_ST, {4'h0, ext});
        wr(ppu_pkg::A_CLR, 8'h1F);
        wr(ppu_pkg::A_EN, 8'h10);
        wr(ppu_pkg::A_DATA, 8'h3C);
        nap(4);
        chk(irq_o, 1'b0);
        rd(ppu_pkg::A_ST, 8'h0F);
        rd(ppu_pkg::A_CLR, 8'h00);
        // supply mode on pin 2, then an overload
        wr(ppu_pkg::A_CLR, 8'h1F);
        wr(ppu_pkg::A_MODE, 8'h03);
        nap(1);
        chk(supply_on_o, 1'b1);
        @(posedge clk_sys_i);
        ovl <= 1'b1;
        nap(5);
        chk(irq_o, 1'b1);
        rd(ppu_pkg::A_ST, 8'h10);
        summarize();
    end
endmodule
`default_nettype wire
